/* hdl/timing_storage_pkg.sv */
// Constants and types shared by the transitional timing storage design
package timing_storage_pkg;
	// ==========================================================
	// Widths and depths
	localparam int PAIR_W = 34;
	localparam int HALF_W = 17;
	localparam int MEM_PER_CHAN = 4096;
	localparam int DATA_DEPTH = MEM_PER_CHAN / 2;
	localparam int ADDR_W = 11;
	localparam int TAG_W = 32;
	localparam int POD_PAIRS = 4;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int SAMPLE_DIV = 2;
	localparam int HALT_WAIT_MS = 2000;
	localparam int HALT_CYCLES = HALT_WAIT_MS * 1000 * CLK_MHZ;
	localparam int HALT_CNT_W = 32;
	localparam int DIV_W = 8;
	// ==========================================================
	// Per pod pair store state
	typedef enum logic [3:0] {
		wait_ref = 4'h1,
		watch = 4'h2,
		second = 4'h4,
		done = 4'h8
	} store_state_t;
endpackage : timing_storage_pkg

/* hdl/trace_ram.sv */
// Trace memory for one pod pair: sample word plus time tag
`timescale 1ns/1ps
module trace_ram #(
	parameter int WIDTH = 66,
	parameter int DEPTH = 2048,
	parameter int AW = 11
) (
	// Clock
	input wire logic sys_clk_i,
	// Write side
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	// Read side
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule : trace_ram

/* hdl/transitional_timing_storage.sv */
// Transitional timing store qualification with per pod pair trace memory
// What this block does
// - Sample at a regular rate; store only on changes of enabled bits of a pair.
// - Any enabled change stores every bit of that pod pair.
// - Every stored sample carries its time tag.
// - Store qualification comes from transition detectors; sampling uses the internal clock.
// - Of 4 K per channel, 2 K hold time tags, the rest data.
// - All pod pairs sample at one shared rate and take time tags from one shared counter.
// - No borrowing of a free pod's memory to keep tag depth.
// - Transition after a quiet sample stores preceding and current samples.
// - Transition right after a transition stores only the current sample.
// - Quiet sample writes nothing; next transition stores two samples again.
// - First stored sample is the reference, not a transition.
// - Half-channel mode latches a 17-bit sample and sends it with the next.
// - Single run pairs independent; repetitive full pair waits 2 s, halts all.
// - Disabled lines not examined, but captured when an enabled line stores.
`timescale 1ns/1ps
module transitional_timing_storage #(
	parameter int PAIRS = timing_storage_pkg::POD_PAIRS,
	parameter int SAMPLE_DIV = timing_storage_pkg::SAMPLE_DIV,
	parameter int HALT_CYCLES = timing_storage_pkg::HALT_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Probe pins and channel enables
	input wire logic [PAIRS*timing_storage_pkg::PAIR_W-1:0] probe_i,
	input wire logic [PAIRS*timing_storage_pkg::PAIR_W-1:0] chan_en_i,
	// Run control
	input wire logic arm_i,
	input wire logic half_mode_i,
	input wire logic repetitive_i,
	// Trace readback
	input wire logic [timing_storage_pkg::ADDR_W-1:0] rd_addr_i,
	output logic [PAIRS*(timing_storage_pkg::PAIR_W+timing_storage_pkg::TAG_W)-1:0] rd_data_o,
	// Status
	output logic [PAIRS*(timing_storage_pkg::ADDR_W+1)-1:0] stored_cnt_o,
	output logic [PAIRS-1:0] pair_full_o,
	output logic halted_o
);
	localparam int PW = timing_storage_pkg::PAIR_W;
	localparam int HW = timing_storage_pkg::HALF_W;
	localparam int TW = timing_storage_pkg::TAG_W;
	localparam int AW = timing_storage_pkg::ADDR_W;
	localparam int WW = PW + TW;
	localparam int DW = timing_storage_pkg::DIV_W;
	localparam int CW = timing_storage_pkg::HALT_CNT_W;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(timing_storage_pkg::DATA_DEPTH);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// Enabled bits of one pair; half mode folds the low pod onto both halves
	function automatic logic [PW-1:0] pair_mask(input logic [PW-1:0] en, input logic half);
		pair_mask = half ? {en[HW-1:0], en[HW-1:0]} : en;
	endfunction : pair_mask

	// ==========================================================
	// Pin synchronisers
	logic [PAIRS*PW-1:0] probe_meta;
	logic [PAIRS*PW-1:0] probe_sync;
	always_ff @(posedge sys_clk_i) begin
		probe_meta <= probe_i;
		probe_sync <= probe_meta;
	end

	// ==========================================================
	// Internal sample clock divider and half-channel pipeline
	logic [DW-1:0] div_cnt, next_div_cnt;
	logic sample_en;
	logic half_phase, next_half_phase;
	logic pipe_valid, next_pipe_valid;
	logic [PW-1:0] pipe_data [PAIRS];
	logic [PW-1:0] next_pipe_data [PAIRS];
	logic [HW-1:0] held [PAIRS];
	logic [HW-1:0] next_held [PAIRS];
	logic [TW-1:0] tag_cnt, next_tag_cnt;
	logic [TW-1:0] pipe_tag, next_pipe_tag;
	logic armed, next_armed;
	logic halt_all, next_halt_all;
	logic [CW-1:0] halt_cnt, next_halt_cnt;

	assign sample_en = (div_cnt == DW'(SAMPLE_DIV - 1));

	always_comb begin
		next_div_cnt = sample_en ? '0 : div_cnt + DW'(1);
		next_half_phase = half_phase;
		next_pipe_valid = 1'b0;
		next_pipe_tag = tag_cnt;
		next_tag_cnt = tag_cnt;
		for (int p = 0; p < PAIRS; p++) begin
			next_held[p] = held[p];
			next_pipe_data[p] = pipe_data[p];
		end
		if (sample_en) begin
			if (half_mode_i) begin
				next_half_phase = !half_phase;
				for (int p = 0; p < PAIRS; p++) begin
					if (!half_phase) begin
						next_held[p] = probe_sync[p*PW +: HW];
					end else begin
						next_pipe_data[p] = {probe_sync[p*PW +: HW], held[p]};
					end
				end
				next_pipe_valid = half_phase;
			end else begin
				next_half_phase = 1'b0;
				for (int p = 0; p < PAIRS; p++) begin
					next_pipe_data[p] = probe_sync[p*PW +: PW];
				end
				next_pipe_valid = 1'b1;
			end
		end
		if (next_pipe_valid) begin
			next_tag_cnt = tag_cnt + TW'(1);
		end
		if (arm_i) begin
			next_pipe_tag = '0;
			next_tag_cnt = next_pipe_valid ? TW'(1) : '0;
			next_half_phase = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			div_cnt <= '0;
			half_phase <= 1'b0;
			pipe_valid <= 1'b0;
			pipe_tag <= '0;
			tag_cnt <= '0;
			for (int p = 0; p < PAIRS; p++) begin
				held[p] <= '0;
				pipe_data[p] <= '0;
			end
		end else begin
			div_cnt <= next_div_cnt;
			half_phase <= next_half_phase;
			pipe_valid <= next_pipe_valid;
			pipe_tag <= next_pipe_tag;
			tag_cnt <= next_tag_cnt;
			held <= next_held;
			pipe_data <= next_pipe_data;
		end
	end

	// ==========================================================
	// Run control and repetitive halt timer
	always_comb begin
		next_armed = armed;
		next_halt_all = halt_all;
		next_halt_cnt = halt_cnt;
		if (repetitive_i && (|pair_full_o) && !halt_all) begin
			if (halt_cnt == CW'(HALT_CYCLES - 1)) begin
				next_halt_all = 1'b1;
				next_armed = 1'b0;
			end else begin
				next_halt_cnt = halt_cnt + CW'(1);
			end
		end
		if (arm_i) begin
			next_armed = 1'b1;
			next_halt_all = 1'b0;
			next_halt_cnt = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			armed <= 1'b0;
			halt_all <= 1'b0;
			halt_cnt <= '0;
		end else begin
			armed <= next_armed;
			halt_all <= next_halt_all;
			halt_cnt <= next_halt_cnt;
		end
	end

	assign halted_o = halt_all;

	a_single_no_halt: assert property (!repetitive_i && !halt_all |=> !halt_all)
		else $error("single run halted pod pairs");
	a_halt_after_wait: assert property (repetitive_i && (|pair_full_o) && !halt_all && !arm_i
		&& halt_cnt == CW'(HALT_CYCLES - 1) |=> halt_all)
		else $error("repetitive halt not raised after wait");

	// ==========================================================
	// Per pod pair store qualification, tags from the shared counter, own memory
	timing_storage_pkg::store_state_t st [PAIRS];
	timing_storage_pkg::store_state_t next_st [PAIRS];
	logic [PW-1:0] prev_data [PAIRS];
	logic [PW-1:0] next_prev_data [PAIRS];
	logic [TW-1:0] prev_tag [PAIRS];
	logic [TW-1:0] next_prev_tag [PAIRS];
	logic prev_trans [PAIRS];
	logic next_prev_trans [PAIRS];
	logic [WW-1:0] hold_word [PAIRS];
	logic [WW-1:0] next_hold_word [PAIRS];
	logic [AW:0] ptr [PAIRS];
	logic [AW:0] next_ptr [PAIRS];
	logic wr_en [PAIRS];
	logic [WW-1:0] wr_word [PAIRS];
	logic trans [PAIRS];

	for (genvar g = 0; g < PAIRS; g++) begin : g_pair
		// Only enabled lines are compared; all bits get stored
		assign trans[g] = |((pipe_data[g] ^ prev_data[g])
			& pair_mask(chan_en_i[g*PW +: PW], half_mode_i));

		always_comb begin
			next_st[g] = st[g];
			next_prev_data[g] = prev_data[g];
			next_prev_tag[g] = prev_tag[g];
			next_prev_trans[g] = prev_trans[g];
			next_hold_word[g] = hold_word[g];
			next_ptr[g] = ptr[g];
			wr_en[g] = 1'b0;
			wr_word[g] = '0;
			case (st[g])
				timing_storage_pkg::wait_ref: begin
					if (armed && pipe_valid) begin
						wr_en[g] = 1'b1;
						wr_word[g] = {pipe_tag, pipe_data[g]};
						next_ptr[g] = ptr[g] + (AW+1)'(1);
						next_prev_data[g] = pipe_data[g];
						next_prev_tag[g] = pipe_tag;
						next_prev_trans[g] = 1'b0;
						next_st[g] = timing_storage_pkg::watch;
					end
				end
				timing_storage_pkg::watch: begin
					if (pipe_valid) begin
						next_prev_data[g] = pipe_data[g];
						next_prev_tag[g] = pipe_tag;
						next_prev_trans[g] = trans[g];
						if (trans[g]) begin
							wr_en[g] = 1'b1;
							next_ptr[g] = ptr[g] + (AW+1)'(1);
							if (prev_trans[g]) begin
								wr_word[g] = {pipe_tag, pipe_data[g]};
							end else begin
								wr_word[g] = {prev_tag[g], prev_data[g]};
								next_hold_word[g] = {pipe_tag, pipe_data[g]};
								next_st[g] = timing_storage_pkg::second;
							end
						end
					end
				end
				timing_storage_pkg::second: begin
					wr_en[g] = 1'b1;
					wr_word[g] = hold_word[g];
					next_ptr[g] = ptr[g] + (AW+1)'(1);
					next_st[g] = timing_storage_pkg::watch;
				end
				timing_storage_pkg::done: begin
				end
				default: begin
					next_st[g] = timing_storage_pkg::wait_ref;
				end
			endcase
			if (next_ptr[g] == FULL_CNT || halt_all) begin
				next_st[g] = timing_storage_pkg::done;
			end
			if (arm_i) begin
				next_st[g] = timing_storage_pkg::wait_ref;
				next_ptr[g] = '0;
				next_prev_trans[g] = 1'b0;
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (!nrst_i) begin
				st[g] <= timing_storage_pkg::done;
				prev_data[g] <= '0;
				prev_tag[g] <= '0;
				prev_trans[g] <= 1'b0;
				hold_word[g] <= '0;
				ptr[g] <= '0;
			end else begin
				st[g] <= next_st[g];
				prev_data[g] <= next_prev_data[g];
				prev_tag[g] <= next_prev_tag[g];
				prev_trans[g] <= next_prev_trans[g];
				hold_word[g] <= next_hold_word[g];
				ptr[g] <= next_ptr[g];
			end
		end

		// Separate memory per pair; no borrowing across pairs
		trace_ram #(
			.WIDTH(WW),
			.DEPTH(timing_storage_pkg::DATA_DEPTH),
			.AW(AW)
		) u_ram (
			.sys_clk_i(sys_clk_i),
			.wr_en_i(wr_en[g]),
			.wr_addr_i(ptr[g][AW-1:0]),
			.wr_data_i(wr_word[g]),
			.rd_addr_i(rd_addr_i),
			.rd_data_o(rd_data_o[g*WW +: WW])
		);

		assign stored_cnt_o[g*(AW+1) +: AW+1] = ptr[g];
		assign pair_full_o[g] = (st[g] == timing_storage_pkg::done) && (ptr[g] == FULL_CNT);

		sequence s_prev_write;
			wr_en[g] && wr_word[g] == {prev_tag[g], prev_data[g]};
		endsequence
		sequence s_cur_write(logic [WW-1:0] w);
			wr_en[g] && wr_word[g] == w;
		endsequence

		a_pair_store: assert property (st[g] == timing_storage_pkg::watch && pipe_valid
			&& trans[g] && !prev_trans[g] && !arm_i && !halt_all && ptr[g] < FULL_CNT - 2
			|-> s_prev_write ##1 s_cur_write($past({pipe_tag, pipe_data[g]})))
			else $error("two-sample store missing");
		a_single_store: assert property (st[g] == timing_storage_pkg::watch && pipe_valid
			&& trans[g] && prev_trans[g] && !arm_i
			|-> wr_en[g] && wr_word[g][PW-1:0] == pipe_data[g] ##1 !wr_en[g])
			else $error("back to back transition stored wrong");
		a_quiet_no_write: assert property (st[g] == timing_storage_pkg::watch
			&& !(pipe_valid && trans[g]) |-> !wr_en[g])
			else $error("write without transition");
		a_ref_sample: assert property (st[g] == timing_storage_pkg::wait_ref && armed
			&& pipe_valid && !arm_i && !halt_all |-> wr_en[g] ##1 st[g] != timing_storage_pkg::wait_ref)
			else $error("reference sample not stored");
		a_full_stops: assert property (pair_full_o[g] && !arm_i |=> !wr_en[g] && ptr[g] == FULL_CNT)
			else $error("write after memory full");
		a_ptr_advance: assert property (wr_en[g] && !arm_i |=> ptr[g] == $past(ptr[g]) + (AW+1)'(1))
			else $error("write pointer did not advance");
	end : g_pair
endmodule : transitional_timing_storage

/* bench/probe_model.sv */
// Behavioural model of the probed target lines
`timescale 1ns/1ps
module probe_model #(
	parameter int WIDTH = 68
) (
	// Clock
	input wire logic sys_clk_i,
	// Commanded levels
	input wire logic [WIDTH-1:0] level_i,
	// Probe lines
	output logic [WIDTH-1:0] probe_o
);
	// ==========================================================
	// Lines move just after an edge, like a synchronous target
	initial probe_o = '0;
	always @(posedge sys_clk_i) begin
		probe_o <= #1 level_i;
	end
endmodule : probe_model

/* bench/transitional_timing_storage_tb.sv */
// Self-checking bench for the transitional timing storage block
`timescale 1ns/1ps
module transitional_timing_storage_tb;
	localparam int NP = 2;
	localparam int W = timing_storage_pkg::PAIR_W;
	localparam int DW = W + timing_storage_pkg::TAG_W;
	localparam int CW = timing_storage_pkg::ADDR_W + 1;
	localparam int HC = 20;
	logic sys_clk_i, nrst_i, arm_i, half_mode_i, repetitive_i, halted_o;
	logic [NP*W-1:0] level, probe_w, chan_en_i;
	logic [timing_storage_pkg::ADDR_W-1:0] rd_addr_i;
	logic [NP*DW-1:0] rd_data_o;
	logic [NP*CW-1:0] stored_cnt_o;
	logic [NP-1:0] pair_full_o;
	logic [W-1:0] cur0;
	logic [W-1:0] exp_q[$];
	logic [DW-1:0] word, last;
	int n_errors, n_compared, seed;
	// ==========================================================
	// Far side and device
	probe_model #(.WIDTH(NP*W)) probe_u (.sys_clk_i(sys_clk_i), .level_i(level),
		.probe_o(probe_w));
	transitional_timing_storage #(.PAIRS(NP), .SAMPLE_DIV(2), .HALT_CYCLES(HC)) dut_u (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .probe_i(probe_w), .chan_en_i(chan_en_i),
		.arm_i(arm_i), .half_mode_i(half_mode_i), .repetitive_i(repetitive_i),
		.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .stored_cnt_o(stored_cnt_o),
		.pair_full_o(pair_full_o), .halted_o(halted_o));
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// ==========================================================
	// Helpers
	task step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : step
	task check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wrap_up;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	function automatic logic [W-1:0] en_change();
		return W'(($random(seed) & 32'h0001_FFFF) | 32'h1);
	endfunction : en_change
	function automatic logic [DW-1:0] cnt(input int p);
		return DW'(stored_cnt_o[p*CW+:CW]);
	endfunction : cnt
	// Changes on enabled bits, one per sample period
	task burst(input int k, input bit keep);
		if (keep) exp_q.push_back(cur0);
		for (int i = 0; i < k; i++) begin
			cur0 = cur0 ^ en_change();
			if (keep) exp_q.push_back(cur0);
			level[W-1:0] = cur0;
			step(2);
		end
		step(12);
	endtask : burst
	task arm;
		arm_i = 1'b1;
		step(1);
		arm_i = 1'b0;
		step(12);
	endtask : arm
	task fill_pair0;
		burst(2046, 1'b0);
		for (int i = 0; i < 50 && pair_full_o[0] !== 1'b1; i++) step(1);
		check("pair0 full", DW'(pair_full_o[0]), 1);
		if (pair_full_o[0] !== 1'b1) wrap_up();
		check("pair0 count", cnt(0), 2048);
	endtask : fill_pair0
	// ==========================================================
	// Main sequence
	initial begin
		seed = 13;
		nrst_i = 1'b0;
		arm_i = 1'b0;
		half_mode_i = 1'b0;
		repetitive_i = 1'b0;
		rd_addr_i = '0;
		level = '0;
		cur0 = '0;
		chan_en_i = {{W{1'b1}}, {(W-17){1'b0}}, {17{1'b1}}};
		step(5);
		nrst_i = 1'b1;
		level = {W'(3), W'(0)};
		step(12);
		check("count before arm", cnt(0), 0);
		level = '0;
		step(12);
		arm();
		check("pair0 reference", cnt(0), 1);
		check("pair1 reference", cnt(1), 1);
		exp_q.push_back(cur0);
		cur0[W-1:17] = 17'($random(seed)) | 17'h1;
		level[W-1:0] = cur0;
		step(14);
		check("disabled change", cnt(0), 1);
		burst(1, 1'b1);
		check("single change", cnt(0), 3);
		burst(5, 1'b1);
		check("burst", cnt(0), 9);
		burst(1, 1'b1);
		check("after quiet", cnt(0), 11);
		check("pair1 untouched", cnt(1), 1);
		for (int i = 0; i < exp_q.size(); i++) begin
			rd_addr_i = 11'(i);
			step(2);
			word = rd_data_o[DW-1:0];
			check("stored sample", DW'(word[W-1:0]), DW'(exp_q[i]));
			if (i == 0) check("first tag", DW'(word[DW-1:W]), 0);
			if (i == 0) check("pair1 first word", rd_data_o[2*DW-1:DW], 0);
			if (i > 0) check("tag step", DW'((word[DW-1:W] - last[DW-1:W]) == 32'h1),
				DW'(!(i inside {1, 3, 9})));
			last = word;
		end
		fill_pair0();
		burst(10, 1'b0);
		check("no write when full", cnt(0), 2048);
		check("no halt single", DW'(halted_o), 0);
		level[2*W-1:W] = W'(5);
		step(14);
		check("pair1 still runs", cnt(1), 3);
		repetitive_i = 1'b1;
		arm();
		fill_pair0();
		check("halt waits", DW'(halted_o), 0);
		step(HC + 8);
		check("halt fires", DW'(halted_o), 1);
		level[2*W-1:W] = W'(9);
		step(14);
		check("pair1 halted", cnt(1), 1);
		// ==========================================================
		// Reset after the repetitive halt, then half-channel mode
		nrst_i = 1'b0;
		step(5);
		nrst_i = 1'b1;
		step(2);
		check("halt after reset", DW'(halted_o), 0);
		check("full after reset", DW'(pair_full_o), 0);
		check("count after reset", cnt(0), 0);
		repetitive_i = 1'b0;
		half_mode_i = 1'b1;
		arm();
		check("half reference", cnt(1), 1);
		level[2*W-1:W+17] = 17'($random(seed)) | 17'h1;
		step(16);
		check("half upper pod ignored", cnt(1), 1);
		rd_addr_i = '0;
		step(2);
		check("half pair word", rd_data_o[2*DW-1:DW], {32'h0, 17'h9, 17'h9});
		level[W+16:W] = 17'h9 ^ (17'($random(seed)) | 17'h1);
		step(20);
		check("half change stored", DW'(cnt(1) == 3 || cnt(1) == 4), 1);
		wrap_up();
	end
endmodule : transitional_timing_storage_tb
